/* can_cfg_checker.sv */
// Port-level checker for the CAN config and status block.
// Sees the top module's ports only; attached by bind at the foot.
`timescale 1ns/100ps
`default_nettype none
module can_cfg_checker #(
  parameter [15:0] COUNT_MAX = 16'h270F
) (
  // Clock and reset
  input wire        core_clk_in,
  input wire        srst_in,
  // Parameter port and core state
  input wire [3:0]  par_index_in,
  input wire [15:0] par_rdata_out,
  input wire [1:0]  err_state_in,
  // Core control and fault outputs
  input wire [3:0]  active_rate_out,
  input wire [1:0]  active_protocol_out,
  input wire        autobaud_en_out,
  input wire        comm_enable_out,
  input wire        reinit_out,
  input wire        bus_off_alarm_out,
  input wire        comm_fault_action_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  // Reset itself is the cause here, so it must not disable the check
  a_reset_quiets: assert property (disable iff (1'b0) srst_in |=>
    !reinit_out && !bus_off_alarm_out && !autobaud_en_out) else $error("output active after reset");
  a_reinit_pulse: assert property (reinit_out |=> !reinit_out) else $error("reinit held");
  a_reinit_cause: assert property (reinit_out |->
    (err_state_in == 2'h3 || $past(err_state_in) == 2'h3) && !bus_off_alarm_out) else $error("reinit uncaused");
  a_fault_alarm: assert property (comm_fault_action_out |-> bus_off_alarm_out) else $error("fault no alarm");
  a_alarm_silent: assert property (bus_off_alarm_out |-> !comm_enable_out) else $error("comm on in lockout");
  a_autobaud_proto: assert property (autobaud_en_out |-> active_protocol_out == 2'h2)
    else $error("autobaud outside second protocol");
  a_rate_range: assert property (active_rate_out <= 4'h8) else $error("rate code out of range");
  a_ctrl_code: assert property ($past(par_index_in) == 4'h3 |-> par_rdata_out <= 16'h0006)
    else $error("bad controller state");
  a_count_cap: assert property ($past(par_index_in) >= 4'h4 && $past(par_index_in) <= 4'h7
    |-> par_rdata_out <= COUNT_MAX) else $error("counter past limit");
endmodule // can_cfg_checker

bind can_interface_config_status can_cfg_checker #(.COUNT_MAX(COUNT_MAX)) chk_u (
  .core_clk_in(core_clk_in), .srst_in(srst_in), .par_index_in(par_index_in),
  .par_rdata_out(par_rdata_out), .err_state_in(err_state_in), .active_rate_out(active_rate_out),
  .active_protocol_out(active_protocol_out), .autobaud_en_out(autobaud_en_out),
  .comm_enable_out(comm_enable_out), .reinit_out(reinit_out), .bus_off_alarm_out(bus_off_alarm_out),
  .comm_fault_action_out(comm_fault_action_out));
`default_nettype wire

/* can_cfg_defs.vh */
// Constants for the CAN interface configuration and status block.
// Assumes inclusion by bare name from the same folder.
`ifndef CAN_CFG_DEFS_VH
`define CAN_CFG_DEFS_VH

// Parameter word indices on the parameter port
`define PAR_PROTOCOL      4'h0
`define PAR_BIT_RATE      4'h1
`define PAR_BUS_OFF_POL   4'h2
`define PAR_CTRL_STATE    4'h3
`define PAR_RX_COUNT      4'h4
`define PAR_TX_COUNT      4'h5
`define PAR_BUS_OFF_COUNT 4'h6
`define PAR_LOST_COUNT    4'h7
`define PAR_NET_STATE     4'h8
`define PAR_NODE_STATE    4'h9

// Reset values
`define RST_PROTOCOL      2'h2
`define RST_BIT_RATE      4'h0
`define RST_BUS_OFF_POL   1'h1

// Protocol codes
`define PROTO_NONE        2'h0
`define PROTO_CANOPEN     2'h1
`define PROTO_DEVICENET   2'h2

// Rate codes
`define RATE_1M           4'h0
`define RATE_800K         4'h1
`define RATE_500K         4'h2
`define RATE_250K         4'h3
`define RATE_125K         4'h4
`define RATE_100K         4'h5
`define RATE_50K          4'h6
`define RATE_20K          4'h7
`define RATE_10K          4'h8
`define RATE_MAX          4'h8

// Controller state codes
`define CST_DISABLED      3'h0
`define CST_AUTOBAUD      3'h1
`define CST_ACTIVE        3'h2
`define CST_WARNING       3'h3
`define CST_PASSIVE       3'h4
`define CST_BUS_OFF       3'h5
`define CST_NO_POWER      3'h6

// Network state codes
`define NST_DISABLED      3'h0
`define NST_COMM_EN       3'h2
`define NST_ERR_CTRL      3'h3
`define NST_GUARD_ERR     3'h4
`define NST_HB_ERR        3'h5

// Error controller state codes from the CAN core
`define ERR_ACTIVE        2'h0
`define ERR_WARNING       2'h1
`define ERR_PASSIVE       2'h2
`define ERR_BUS_OFF       2'h3

// Counter limit
`define COUNT_MAX         16'h270F

`endif

/* can_core_model.sv */
// Behavioural CAN core and network standing beyond the block.
// Assumes requests from the bench land just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module can_core_model (
  // Clock
  input  wire       core_clk_in,
  // Requests from the bench
  input  wire       go_in,
  input  wire [1:0] kind_in,
  input  wire [1:0] err_in,
  input  wire [3:0] net_rate_in,
  input  wire       autobaud_en_in,
  // Toward the block
  output reg  [1:0] err_state_out = 2'h0,
  output reg        rx_frame_out = 1'b0,
  output reg        tx_frame_out = 1'b0,
  output reg        lost_frame_out = 1'b0,
  output reg        autobaud_done_out = 1'b0,
  output reg  [3:0] autobaud_rate_out = 4'h0
);
  integer wait_q = 0;
  always @(posedge core_clk_in) begin
    err_state_out <= err_in;
    rx_frame_out <= go_in && kind_in == 2'h0;
    tx_frame_out <= go_in && kind_in == 2'h1;
    lost_frame_out <= go_in && kind_in == 2'h3;
    autobaud_done_out <= 1'b0;
    // Rate is only meaningful with the done pulse, so it wanders otherwise
    autobaud_rate_out <= ~autobaud_rate_out;
    if (!autobaud_en_in) wait_q <= 0;
    else if (wait_q == 10) begin
      autobaud_done_out <= 1'b1;
      autobaud_rate_out <= net_rate_in;
      wait_q <= 11;
    end else if (wait_q < 10) wait_q <= wait_q + 1;
  end
endmodule // can_core_model
`default_nettype wire

/* can_interface_config_status.v */
// Configuration and status parameters of the drive's CAN fieldbus interface.
// Assumes a CAN core on the same clock giving event pulses and error state, and
// a parameter port with word index, write strobe and read data.
// Contract
// - Rate code 0..8 means 1M, 800k, 500k, 250k, 125k, 100k, 50k, 20k, 10k; default 0.
// - CANopen takes every rate code as fixed, never autobauds.
// - DeviceNet fixes only 500, 250, 125k; other codes start autobaud.
// - New rate applies only while unpowered or at power cycle; else pending.
// - Detected rate overwrites rate code; software rewrites autobaud code to retry.
// - Manual policy: bus-off raises alarm, fault action, disables until power cycle.
// - Automatic policy (default): bus-off reinitialises quietly, no alarm or action.
// - Controller state: 0 disabled,1 autobaud,2 active,3 warning,4 passive,5 bus off,6 no power.
// - Controller state reads disabled when no protocol is selected.
// - Controller state reads 6 without bus supply voltage.
// - Controller state reads 1 while searching for the bit rate.
// - Received frame counter 0..9999 counts each received frame.
// - Transmitted frame counter 0..9999 counts each sent frame.
// - Bus-off counter counts each entry into bus off.
// - Lost message counter counts received frames not processed.
// - Counters clear at power-off, reset, and on an event while at maximum.
// - Network state: 0 disabled,1 reserved,2 comm enabled,3 error ctrl,4 guard err,5 hb err.
// - Node state: 0 disabled,1 init,2 stopped,3 operational,4 preoperational.
// - Protocol 1 is CANopen, 2 DeviceNet; it selects rate and autobaud behaviour.
`timescale 1ns/100ps
`default_nettype none
`include "can_cfg_defs.vh"

module can_interface_config_status #(
  parameter [15:0] COUNT_MAX = `COUNT_MAX
) (
  // Clock, reset, enable
  input  wire        core_clk_in,
  input  wire        srst_in,
  input  wire        clk_en_in,
  // Parameter port
  input  wire [3:0]  par_index_in,
  input  wire        par_write_in,
  input  wire [15:0] par_wdata_in,
  output reg  [15:0] par_rdata_out,
  // Supply pin, asynchronous
  input  wire        bus_power_in,
  // CAN core, same clock
  input  wire [1:0]  err_state_in,
  input  wire        rx_frame_in,
  input  wire        tx_frame_in,
  input  wire        lost_frame_in,
  input  wire        autobaud_done_in,
  input  wire [3:0]  autobaud_rate_in,
  input  wire        err_ctrl_active_in,
  input  wire        guard_err_in,
  input  wire        hb_err_in,
  input  wire [2:0]  node_state_in,
  // CAN core control
  output reg  [3:0]  active_rate_out,
  output reg  [1:0]  active_protocol_out,
  output reg         autobaud_en_out,
  output reg         comm_enable_out,
  output reg         reinit_out,
  // Drive fault handling
  output reg         bus_off_alarm_out,
  output reg         comm_fault_action_out
);

  // ----------------------------------------------------------------
  // Supply synchroniser
  // ----------------------------------------------------------------
  reg        pwr_meta_q;
  reg        pwr_q;
  reg        pwr_prev_q;
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      pwr_meta_q <= 1'b0;
      pwr_q      <= 1'b0;
      pwr_prev_q <= 1'b0;
    end else if (clk_en_in) begin
      pwr_meta_q <= bus_power_in;
      pwr_q      <= pwr_meta_q;
      pwr_prev_q <= pwr_q;
    end
  end
  wire power_off_edge = pwr_prev_q & ~pwr_q;

  // ----------------------------------------------------------------
  // Software parameters
  // ----------------------------------------------------------------
  reg [1:0]  protocol_q;
  reg [3:0]  bit_rate_q;
  reg        bus_off_pol_q;
  reg        bus_off_q;
  reg        latched_off_q;
  // Out-of-range writes are dropped so each stored word always holds a legal code
  wire       rate_ok     = (par_wdata_in[15:4] == 12'h000) & (par_wdata_in[3:0] <= `RATE_MAX);
  wire       proto_ok    = (par_wdata_in == 16'h0001) | (par_wdata_in == 16'h0002);
  wire       pol_ok      = (par_wdata_in[15:1] == 15'h0000);
  wire       wr_rate     = par_write_in & (par_index_in == `PAR_BIT_RATE) & rate_ok;
  wire       wr_protocol = par_write_in & (par_index_in == `PAR_PROTOCOL) & proto_ok;
  wire       wr_policy   = par_write_in & (par_index_in == `PAR_BUS_OFF_POL) & pol_ok;
  // A detected code outside the table is ignored rather than applied
  wire       ab_take     = autobaud_done_in & autobaud_en_out & (autobaud_rate_in <= `RATE_MAX);

  // Codes a DeviceNet node can run fixed
  function is_fixed;
    input [1:0] proto;
    input [3:0] rate;
    begin
      if (proto == `PROTO_CANOPEN) begin
        is_fixed = 1'b1;
      end else begin
        is_fixed = (rate == `RATE_500K) | (rate == `RATE_250K) | (rate == `RATE_125K);
      end
    end
  endfunction

  always @(posedge core_clk_in) begin
    if (srst_in) begin
      protocol_q    <= `RST_PROTOCOL;
      bit_rate_q    <= `RST_BIT_RATE;
      bus_off_pol_q <= `RST_BUS_OFF_POL;
    end else if (clk_en_in) begin
      // Detection result wins over a same-cycle write
      if (ab_take) begin
        bit_rate_q <= autobaud_rate_in;
      end else if (wr_rate) begin
        bit_rate_q <= par_wdata_in[3:0];
      end
      if (wr_protocol) begin
        protocol_q <= par_wdata_in[1:0];
      end
      if (wr_policy) begin
        bus_off_pol_q <= par_wdata_in[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus-off policy
  // ----------------------------------------------------------------
  // Entry is the rising edge of the bus-off level, only while powered
  wire       bus_off_entry = (err_state_in == `ERR_BUS_OFF) & ~bus_off_q & pwr_q;
  wire       lockout_now   = bus_off_entry & ~bus_off_pol_q;
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      reinit_out            <= 1'b0;
      bus_off_alarm_out     <= 1'b0;
      comm_fault_action_out <= 1'b0;
      bus_off_q             <= 1'b0;
      latched_off_q         <= 1'b0;
    end else if (clk_en_in) begin
      bus_off_q             <= (err_state_in == `ERR_BUS_OFF);
      reinit_out            <= bus_off_entry & bus_off_pol_q;
      comm_fault_action_out <= lockout_now;
      // Power loss counts as the power cycle that releases a manual lockout
      if (power_off_edge) begin
        latched_off_q     <= 1'b0;
        bus_off_alarm_out <= 1'b0;
      end else if (lockout_now) begin
        latched_off_q     <= 1'b1;
        bus_off_alarm_out <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Applied configuration
  // ----------------------------------------------------------------
  // Settings only reach the core while unpowered, so a change while running waits.
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      active_rate_out     <= `RST_BIT_RATE;
      active_protocol_out <= `PROTO_NONE;
      autobaud_en_out     <= 1'b0;
      comm_enable_out     <= 1'b0;
    end else if (clk_en_in) begin
      if (~pwr_q) begin
        active_rate_out     <= bit_rate_q;
        active_protocol_out <= protocol_q;
        autobaud_en_out     <= ~is_fixed(protocol_q, bit_rate_q);
        comm_enable_out     <= 1'b0;
      end else begin
        // Lockout takes hold in the very cycle of the bus-off entry
        comm_enable_out     <= ~latched_off_q & ~lockout_now;
        if (ab_take) begin
          active_rate_out   <= autobaud_rate_in;
          autobaud_en_out   <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Event counters
  // ----------------------------------------------------------------
  wire [15:0] rx_cnt;
  wire [15:0] tx_cnt;
  wire [15:0] bo_cnt;
  wire [15:0] lost_cnt;

  event_counter #(.MAX_COUNT(COUNT_MAX)) u_rx_count (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .clk_en_in   (clk_en_in),
    .clear_in    (power_off_edge),
    .event_in    (rx_frame_in),
    .count_out   (rx_cnt)
  );
  event_counter #(.MAX_COUNT(COUNT_MAX)) u_tx_count (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .clk_en_in   (clk_en_in),
    .clear_in    (power_off_edge),
    .event_in    (tx_frame_in),
    .count_out   (tx_cnt)
  );
  event_counter #(.MAX_COUNT(COUNT_MAX)) u_bus_off_count (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .clk_en_in   (clk_en_in),
    .clear_in    (power_off_edge),
    .event_in    (bus_off_entry),
    .count_out   (bo_cnt)
  );
  event_counter #(.MAX_COUNT(COUNT_MAX)) u_lost_count (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .clk_en_in   (clk_en_in),
    .clear_in    (power_off_edge),
    .event_in    (lost_frame_in),
    .count_out   (lost_cnt)
  );

  // ----------------------------------------------------------------
  // Status decode
  // ----------------------------------------------------------------
  reg [2:0] ctrl_state;
  reg [2:0] net_state;
  reg [2:0] node_state;
  always @* begin
    if (active_protocol_out == `PROTO_NONE) begin
      ctrl_state = `CST_DISABLED;
    end else if (~pwr_q) begin
      ctrl_state = `CST_NO_POWER;
    end else if (autobaud_en_out) begin
      ctrl_state = `CST_AUTOBAUD;
    end else if (latched_off_q) begin
      ctrl_state = `CST_BUS_OFF;
    end else begin
      case (err_state_in)
        `ERR_ACTIVE:  ctrl_state = `CST_ACTIVE;
        `ERR_WARNING: ctrl_state = `CST_WARNING;
        `ERR_PASSIVE: ctrl_state = `CST_PASSIVE;
        default:      ctrl_state = `CST_BUS_OFF;
      endcase
    end
  end

  // Network and node status only mean something under CANopen
  wire canopen_live = (active_protocol_out == `PROTO_CANOPEN) & comm_enable_out;
  always @* begin
    if (~canopen_live) begin
      net_state = `NST_DISABLED;
    end else if (guard_err_in) begin
      net_state = `NST_GUARD_ERR;
    end else if (hb_err_in) begin
      net_state = `NST_HB_ERR;
    end else if (err_ctrl_active_in) begin
      net_state = `NST_ERR_CTRL;
    end else begin
      net_state = `NST_COMM_EN;
    end
  end

  // Codes above preoperational are no slave state, so they read as disabled
  always @* begin
    node_state = 3'h0;
    if (canopen_live) begin
      case (node_state_in)
        3'h1:    node_state = 3'h1;
        3'h2:    node_state = 3'h2;
        3'h3:    node_state = 3'h3;
        3'h4:    node_state = 3'h4;
        default: node_state = 3'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data, registered
  // ----------------------------------------------------------------
  reg [15:0] rdata_d;
  // Short fields padded to the full word
  wire [15:0] protocol_word = {14'h0000, protocol_q};
  wire [15:0] rate_word     = {12'h000, bit_rate_q};
  wire [15:0] policy_word   = {15'h0000, bus_off_pol_q};
  wire [15:0] ctrl_word     = {13'h0000, ctrl_state};
  wire [15:0] net_word      = {13'h0000, net_state};
  wire [15:0] node_word     = {13'h0000, node_state};
  always @* begin
    case (par_index_in)
      `PAR_PROTOCOL:      rdata_d = protocol_word;
      `PAR_BIT_RATE:      rdata_d = rate_word;
      `PAR_BUS_OFF_POL:   rdata_d = policy_word;
      `PAR_CTRL_STATE:    rdata_d = ctrl_word;
      `PAR_RX_COUNT:      rdata_d = rx_cnt;
      `PAR_TX_COUNT:      rdata_d = tx_cnt;
      `PAR_BUS_OFF_COUNT: rdata_d = bo_cnt;
      `PAR_LOST_COUNT:    rdata_d = lost_cnt;
      `PAR_NET_STATE:     rdata_d = net_word;
      `PAR_NODE_STATE:    rdata_d = node_word;
      default:            rdata_d = 16'h0000;
    endcase
  end

  always @(posedge core_clk_in) begin
    if (srst_in) begin
      par_rdata_out <= 16'h0000;
    end else if (clk_en_in) begin
      par_rdata_out <= rdata_d;
    end
  end

endmodule // can_interface_config_status

`default_nettype wire

/* can_interface_config_status_tb.sv */
// Self-checking bench for the CAN config and status block.
// Drives the parameter port and the core model; counters shrunk to 15.
`timescale 1ns/100ps
`default_nettype none
module can_interface_config_status_tb;
  localparam [15:0] CMAX = 16'h000F;
  reg         core_clk_in = 1'b0;
  reg         srst_in = 1'b1;
  reg  [3:0]  idx = 4'h0;
  reg         wr_en = 1'b0;
  reg  [15:0] wdata = 16'h0000;
  reg         pwr = 1'b0;
  reg         go = 1'b0;
  reg  [1:0]  kind = 2'h0;
  reg  [1:0]  err = 2'h0;
  reg         ce = 1'b1;
  reg  [2:0]  nerr = 3'h0;
  reg  [2:0]  node = 3'h3;
  wire [15:0] rdata;
  wire [1:0]  err_st, act_proto;
  wire [3:0]  ab_rate, act_rate;
  wire        rx, tx, lost, ab_done, ab_en, comm_en, reinit, alarm, fault;
  integer     n_errors = 0, num_checks = 0, seed = 53087, r, i, c;
  integer     cnt [0:3];

  can_interface_config_status #(.COUNT_MAX(CMAX)) dut_u (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .clk_en_in(ce), .par_index_in(idx),
    .par_write_in(wr_en), .par_wdata_in(wdata), .par_rdata_out(rdata), .bus_power_in(pwr),
    .err_state_in(err_st), .rx_frame_in(rx), .tx_frame_in(tx), .lost_frame_in(lost),
    .autobaud_done_in(ab_done), .autobaud_rate_in(ab_rate), .err_ctrl_active_in(nerr[0]),
    .guard_err_in(nerr[1]), .hb_err_in(nerr[2]), .node_state_in(node), .active_rate_out(act_rate),
    .active_protocol_out(act_proto), .autobaud_en_out(ab_en), .comm_enable_out(comm_en),
    .reinit_out(reinit), .bus_off_alarm_out(alarm), .comm_fault_action_out(fault));
  // A dead bus carries no traffic, so the core only searches while powered
  can_core_model core_u (
    .core_clk_in(core_clk_in), .go_in(go), .kind_in(kind), .err_in(err), .net_rate_in(4'h3),
    .autobaud_en_in(ab_en & pwr), .err_state_out(err_st), .rx_frame_out(rx), .tx_frame_out(tx),
    .lost_frame_out(lost), .autobaud_done_out(ab_done), .autobaud_rate_out(ab_rate));

  initial forever #50 core_clk_in = ~core_clk_in;
  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  task t(input integer n); begin repeat (n) @(posedge core_clk_in); #10; end endtask
  task chk(input [15:0] got, input [15:0] exp); begin
    num_checks = num_checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  end endtask
  task wr(input [3:0] a, input [15:0] d); begin
    idx = a; wdata = d; wr_en = 1'b1; t(1); wr_en = 1'b0; t(1);
  end endtask
  task rd(input [3:0] a, input [15:0] e); begin idx = a; t(2); chk(rdata, e); end endtask
  // Falling supply counts as a power cycle, so model counters clear too
  task pw(input v); begin
    pwr = v; t(5);
    if (!v) for (i = 0; i < 4; i = i + 1) cnt[i] = 0;
  end endtask
  task bump(input integer k); cnt[k] = (cnt[k] == CMAX) ? 0 : cnt[k] + 1; endtask
  task wt(input s); begin
    for (i = 0; i < 8 && (s ? alarm : reinit) !== 1'b1; i = i + 1) t(1);
    chk(s ? alarm : reinit, 1);
  end endtask
  task close_out; begin
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  end endtask

  initial begin #5000000; n_errors = n_errors + 1; close_out; end
  initial begin
    for (i = 0; i < 4; i = i + 1) cnt[i] = 0;
    t(2); srst_in = 1'b0; t(4);
    rd(0, 2);
    rd(1, 0);
    rd(2, 1);
    rd(3, 6);
    for (c = 0; c < 10; c = c + 1) begin
      wr(1, c);
      rd(1, c > 8 ? 8 : c);
    end
    for (c = 0; c < 9; c = c + 1) begin
      pw(0); wr(1, c); t(4); pw(1);
      chk(ab_en, c < 2 || c > 4);
    end
    rd(3, 1);
    t(12); rd(1, 3);
    chk(ab_en, 0);
    pw(0); wr(0, 1); wr(1, 5); t(4);
    chk(act_rate, 5);
    chk(act_proto, 1);
    pw(1);
    chk(ab_en, 0);
    rd(3, 2);
    rd(8, 2);
    rd(9, 3);
    nerr = 3'h1; rd(8, 3);
    nerr = 3'h4; rd(8, 5);
    nerr = 3'h6; node = 3'h7; rd(8, 4);
    rd(9, 0);
    nerr = 3'h0; node = 3'h3;
    wr(1, 2); t(4);
    chk(act_rate, 5);
    for (c = 0; c < 40; c = c + 1) begin
      r = $random(seed); kind = r[1:0];
      go = 1'b1; t(1); go = 1'b0; t(1);
      if (kind != 2'h2) bump(kind);
    end
    for (c = 0; c < 4; c = c + 1) if (c != 2) rd(4 + c, cnt[c]);
    // Frozen block must ignore a frame pulse
    ce = 1'b0; kind = 2'h0; go = 1'b1; t(1); go = 1'b0; t(2); ce = 1'b1;
    rd(4, cnt[0]);
    err = 2'h3; wt(0); chk(alarm, 0);
    chk(fault, 0);
    bump(2); err = 2'h0; t(3);
    rd(6, cnt[2]);
    wr(2, 0); err = 2'h3; wt(1); chk(comm_en, 0);
    chk(fault, 1);
    bump(2); err = 2'h0; rd(6, cnt[2]);
    pw(0); chk(alarm, 0);
    rd(4, 0);
    close_out;
  end
endmodule // can_interface_config_status_tb
`default_nettype wire

/* event_counter.v */
// Cyclic 0..max event counter for one class of CAN events.
// Assumes the event input is a single-cycle pulse on the core clock.
`timescale 1ns/100ps
`default_nettype none

module event_counter #(
  parameter [15:0] MAX_COUNT = 16'h270F
) (
  // Clock and control
  input  wire        core_clk_in,
  input  wire        srst_in,
  input  wire        clk_en_in,
  input  wire        clear_in,
  // Event and count
  input  wire        event_in,
  output reg  [15:0] count_out
);

  always @(posedge core_clk_in) begin
    if (srst_in) begin
      count_out <= 16'h0000;
    end else if (clk_en_in) begin
      if (clear_in) begin
        count_out <= 16'h0000;
      end else if (event_in) begin
        if (count_out == MAX_COUNT) begin
          count_out <= 16'h0000;
        end else begin
          count_out <= count_out + 16'h0001;
        end
      end
    end
  end

endmodule // event_counter

`default_nettype wire
